// ===== src/flash_protect.sv
// serial command front end with write-protection decode of the flash array
// assumes the master drives chip select, serial clock and data in modes 0 or 3
`timescale 1ns/1ps
`default_nettype none
module flash_protect
	import flash_protect_pkg::*;
#(
	parameter int PWR_WAIT = PWR_WAIT_CYC
) (
	// core clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// serial pins from the master
	input wire logic sel_n_i,
	input wire logic sclk_i,
	input wire logic serial_in_i,
	input wire logic write_protect_n_i,
	// serial output pin, two signals
	output logic serial_out_line_o,
	output logic serial_out_line_oe_o,
	// protect configuration
	input wire logic protect_size_bit0_i,
	input wire logic protect_size_bit1_i,
	input wire logic protect_size_bit2_i,
	input wire logic top_bottom_select_i,
	input wire logic supply_ok_i,
	// array operation requests to the cell engine
	output logic op_valid_o,
	output logic [2:0] op_kind_o,
	output logic [ADDR_W-1:0] op_addr_o,
	output logic [7:0] op_data_o,
	output logic op_reject_o,
	// status
	output logic write_enable_o,
	output logic [SECTOR_N-1:0] lock_bits_o,
	output logic [SECTOR_N-1:0] lockdown_bits_o
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] s_sel, s_clk, s_din, s_wp, s_pwr;
	logic clk_q;
	always_ff @(posedge mclk_i) begin
		s_sel <= {s_sel[0], sel_n_i};
		s_clk <= {s_clk[0], sclk_i};
		s_din <= {s_din[0], serial_in_i};
		s_wp <= {s_wp[0], write_protect_n_i};
		s_pwr <= {s_pwr[0], supply_ok_i};
		clk_q <= s_clk[1];
	end
	wire logic selected = !s_sel[1];
	// edges found the same way for idle-low or idle-high clock
	wire logic rise = selected && s_clk[1] && !clk_q;
	wire logic fall = selected && !s_clk[1] && clk_q;
	logic sel_q;
	always_ff @(posedge mclk_i) begin
		sel_q <= rst_i ? 1'b0 : selected;
	end
	wire logic deselect = sel_q && !selected;

	// ----------------------------------------
	// supply watchdog timer
	// ----------------------------------------
	logic [$clog2(PWR_WAIT+1)-1:0] pwr_cnt;
	wire logic pwr_ready = (pwr_cnt == ($clog2(PWR_WAIT+1))'(PWR_WAIT));
	always_ff @(posedge mclk_i) begin
		if (rst_i || !s_pwr[1]) begin
			pwr_cnt <= '0;
		end else if (!pwr_ready) begin
			pwr_cnt <= pwr_cnt + 1'b1;
		end
	end

	// ----------------------------------------
	// serial shifter
	// ----------------------------------------
	logic [7:0] shift;
	logic [2:0] bit_cnt;
	logic [12:0] byte_cnt;
	logic [7:0] opcode;
	logic [23:0] addr;
	logic [7:0] data;
	logic [7:0] out_sr;
	wire logic byte_done = rise && bit_cnt == 3'h7;
	wire logic [7:0] next_shift = {shift[6:0], s_din[1]};
	always_ff @(posedge mclk_i) begin
		if (rst_i || !selected) begin
			bit_cnt <= 3'h0;
			byte_cnt <= '0;
		end else if (rise) begin
			shift <= next_shift;
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				byte_cnt <= byte_cnt + 13'h1;
			end
		end
	end

	// capture opcode, address and first data byte
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			opcode <= 8'h00;
			addr <= 24'h0;
			data <= 8'hff;
		end else if (byte_done) begin
			if (byte_cnt == 13'h0) opcode <= next_shift;
			else if (byte_cnt < 13'h4) addr <= {addr[15:0], next_shift};
			else if (byte_cnt == 13'h4) data <= next_shift;
		end
	end

	// ----------------------------------------
	// command decode at deselect
	// ----------------------------------------
	wire logic whole_bytes = bit_cnt == 3'h0;
	wire logic [5:0] sect = addr[SECT_LSB+5:SECT_LSB];
	wire logic is_prog = opcode == OP_PP;
	wire logic is_otp = opcode == OP_POTP;
	wire logic is_sse = opcode == OP_SSE;
	wire logic is_se = opcode == OP_SE;
	wire logic is_be = opcode == OP_BE;
	wire logic is_lock = opcode == OP_WRLR;
	wire logic has_data = byte_cnt >= 13'h5;
	wire logic has_addr = byte_cnt >= 13'h4;
	wire logic array_op = is_prog && has_data || (is_sse || is_se) && has_addr || is_be && byte_cnt == 13'h1;
	wire logic modify = array_op || is_otp && has_data || is_lock && has_data;
	logic wel;
	wire logic [SECTOR_N-1:0] lock_now = lock_bits_o;
	wire logic bp_hit, deny;
	sector_guard sector_guard_i (
		.protect_size_i({protect_size_bit2_i, protect_size_bit1_i, protect_size_bit0_i}),
		.top_bottom_select_i(top_bottom_select_i),
		.wp_active_i(!s_wp[1]),
		.sector_i(sect),
		.whole_array_i(is_be),
		.lock_bit_i(lock_now[sect]),
		.any_lock_i(|lock_now),
		.bp_hit_o(bp_hit),
		.deny_o(deny)
	);
	// a modifying command is carried out only when every gate passes
	wire logic gate_ok = deselect && modify && whole_bytes && wel && pwr_ready;
	wire logic go_array = gate_ok && array_op && !deny;
	wire logic go_otp = gate_ok && is_otp;
	wire logic go_lock = gate_ok && is_lock && !lockdown_bits_o[sect];
	wire logic refused = deselect && modify && !(go_array || go_otp || go_lock);
	wire logic [2:0] next_kind = is_prog ? 3'(OP_PROG_T) : is_sse ? 3'(OP_ERASE_SUB_T) :
		is_se ? 3'(OP_ERASE_SEC_T) : is_be ? 3'(OP_ERASE_ALL_T) : is_otp ? 3'(OP_OTP_T) : 3'(OP_LOCK_T);
	// page program: full address passed on unaligned, page index and offset both kept
	wire logic [ADDR_W-1:0] next_addr = is_sse ? {addr[ADDR_W-1:SUB_LSB], 12'h000} :
		is_se ? {addr[ADDR_W-1:SECT_LSB], 16'h0000} : is_be ? '0 :
		is_otp ? ADDR_W'(addr[OTP_ADDR_W-1:0]) : addr[ADDR_W-1:0];

	// ----------------------------------------
	// write enable latch
	// ----------------------------------------
	wire logic wren_cmd = deselect && whole_bytes && byte_cnt == 13'h1 && opcode == OP_WREN;
	wire logic wrdi_cmd = deselect && whole_bytes && byte_cnt == 13'h1 && opcode == OP_WRDI;
	always_ff @(posedge mclk_i) begin
		if (rst_i || !pwr_ready) begin
			wel <= 1'b0;
		end else if (wren_cmd) begin
			wel <= 1'b1;
		end else if (wrdi_cmd || gate_ok) begin
			wel <= 1'b0; // each whole-byte modify attempt consumes the latch, even a denied one
		end
	end

	// ----------------------------------------
	// sector lock register
	// ----------------------------------------
	// lock-down cleared only by reset, which stands for power cycle too
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			lock_bits_o <= '0;
			lockdown_bits_o <= '0;
		end else if (go_lock) begin
			lock_bits_o[sect] <= data[0];
			lockdown_bits_o[sect] <= data[1];
		end
	end

	// ----------------------------------------
	// operation request to the cell engine
	// ----------------------------------------
	// the engine only pulls bits low on program and high on erase
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			op_valid_o <= 1'b0;
			op_kind_o <= 3'(OP_NONE_T);
			op_addr_o <= '0;
			op_data_o <= 8'hff;
			op_reject_o <= 1'b0;
		end else begin
			op_valid_o <= go_array || go_otp;
			op_reject_o <= refused;
			if (go_array || go_otp) begin
				op_kind_o <= next_kind;
				op_addr_o <= next_addr;
				op_data_o <= data;
			end
		end
	end

	// ----------------------------------------
	// serial output: status on read-status
	// ----------------------------------------
	wire logic load_status = byte_done && byte_cnt == 13'h0 && next_shift == OP_RDSR;
	always_ff @(posedge mclk_i) begin
		if (rst_i || !selected) begin
			serial_out_line_oe_o <= 1'b0;
			serial_out_line_o <= 1'b0;
			out_sr <= 8'h00;
		end else if (load_status) begin
			out_sr <= {1'b0, top_bottom_select_i, 1'b0, protect_size_bit2_i,
				protect_size_bit1_i, protect_size_bit0_i, wel, 1'b0};
		end else if (fall && opcode == OP_RDSR && byte_cnt != 13'h0) begin
			serial_out_line_oe_o <= 1'b1;
			serial_out_line_o <= out_sr[7];
			out_sr <= {out_sr[6:0], out_sr[7]};
		end
	end
	assign write_enable_o = wel;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_no_drive_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_sel[1] |=> !serial_out_line_oe_o) else $error("output driven while deselected");
	a_wel_needed: assert property (@(posedge mclk_i) disable iff (rst_i)
		op_valid_o |-> $past(wel)) else $error("operation without write enable");
	a_partial_byte: assert property (@(posedge mclk_i) disable iff (rst_i)
		(deselect && bit_cnt != 3'h0) |=> !op_valid_o) else $error("partial byte executed");
	a_power_block: assert property (@(posedge mclk_i) disable iff (rst_i)
		!pwr_ready |=> !op_valid_o && $stable(lock_bits_o)) else $error("modify during bad supply");
	a_protect_deny: assert property (@(posedge mclk_i) disable iff (rst_i)
		(deselect && array_op && bp_hit) |=> !op_valid_o) else $error("protected area modified");
	a_lock_deny: assert property (@(posedge mclk_i) disable iff (rst_i)
		(deselect && (is_prog || is_se) && lock_now[sect]) |=> !op_valid_o) else $error("locked sector modified");
	// a frozen target blocks the only writer of the lock bits, so nothing may move
	a_lockdown_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		lockdown_bits_o[sect] |=> $stable(lock_bits_o)) else $error("frozen lock changed");
	// no lock-down bit that is set may fall outside reset
	a_lockdown_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
		(lockdown_bits_o != '0) |=> (lockdown_bits_o & $past(lockdown_bits_o)) == $past(lockdown_bits_o))
		else $error("lock-down cleared");
	a_reject_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
		op_reject_o |=> !op_reject_o) else $error("reject longer than one cycle");
	c_program: cover property (@(posedge mclk_i) op_valid_o && op_kind_o == 3'(OP_PROG_T));
	c_erase_all: cover property (@(posedge mclk_i) op_valid_o && op_kind_o == 3'(OP_ERASE_ALL_T));
	c_rejected: cover property (@(posedge mclk_i) op_reject_o);
	c_lockdown: cover property (@(posedge mclk_i) lockdown_bits_o != '0);
endmodule
`default_nettype wire

// ===== src/flash_protect_pkg.sv
// constants of the serial flash array protection block
// assumes one 50 MHz clock and a master-driven serial clock sampled on it
// Function
// - program only clears bits, erase only sets bits; pages program individually
// - erase by subsector, sector or whole array; no page erase
// - 4 MiB array, 64 sectors, 1024 subsectors, 16384 pages, linear addresses
// - separate 64-byte one-time area outside the main array
// - modifying commands execute only after whole-byte clock counts
// - write enable latch must be set before any modifying command
// - no modification while the supply is outside its range
// - sector write lock bit blocks program and erase of that sector
// - lock-down freezes sector protection until power cycle or reset
// - lock register write updates lock bits unless lock-down is set
// - top/bottom 0: protect codes grow protection down from sector 63
// - top/bottom 1: protect codes grow protection up from sector 0
// - sample input on rising edge, drive output from falling edge
// - both clock modes behave identically in every protocol
// - serial output driven only while selected, released otherwise
// - write-protect pin low locks the block-protected area
package flash_protect_pkg;
	// ----------------------------------------
	// array geometry
	// ----------------------------------------
	localparam int ADDR_W = 22;
	localparam int SECTOR_N = 64;
	localparam int SECT_LSB = 16;
	localparam int SUB_LSB = 12;
	localparam int PAGE_LSB = 8;
	localparam int OTP_BYTES = 64;
	localparam int OTP_ADDR_W = 6;

	// ----------------------------------------
	// command codes (serial opcodes)
	// ----------------------------------------
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_SSE = 8'h20;
	localparam logic [7:0] OP_SE = 8'hd8;
	localparam logic [7:0] OP_BE = 8'hc7;
	localparam logic [7:0] OP_WRLR = 8'he5;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_POTP = 8'h42;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int PWR_WAIT_US = 100;
	localparam int PWR_WAIT_CYC = PWR_WAIT_US * CLK_MHZ;

	typedef enum logic [2:0] {
		OP_NONE_T, OP_PROG_T, OP_ERASE_SUB_T, OP_ERASE_SEC_T, OP_ERASE_ALL_T, OP_LOCK_T, OP_OTP_T
	} op_kind_t;
endpackage

// ===== src/sector_guard.sv
// block-protect decode and final verdict for one addressed sector
// assumes inputs are already on the core clock
`timescale 1ns/1ps
`default_nettype none
module sector_guard
	import flash_protect_pkg::*;
(
	// protect setup
	input wire logic [2:0] protect_size_i,
	input wire logic top_bottom_select_i,
	input wire logic wp_active_i,
	// target
	input wire logic [5:0] sector_i,
	input wire logic whole_array_i,
	input wire logic lock_bit_i,
	input wire logic any_lock_i,
	// verdict
	output logic bp_hit_o,
	output logic deny_o
);
	// number of protected sectors: 0,1,2,4..32, 64
	function automatic logic [6:0] span(input logic [2:0] code);
		span = (code == 3'h0) ? 7'h00 : (code == 3'h7) ? 7'h40 : 7'(7'h01 << (code - 3'h1));
	endfunction

	// ----------------------------------------
	// area decode
	// ----------------------------------------
	wire logic [6:0] count = span(protect_size_i);
	wire logic in_top = {1'b0, sector_i} >= 7'(7'h40 - count);
	wire logic in_bot = {1'b0, sector_i} < count;
	wire logic sect_bp = (count != 7'h00) && (top_bottom_select_i ? in_bot : in_top);
	// whole-array erase hits any protection at all
	assign bp_hit_o = whole_array_i ? (count != 7'h00) : sect_bp;
	// block protect denies whether or not the write-protect pin is active, locks gate on their own
	assign deny_o = bp_hit_o || wp_active_i && bp_hit_o || (whole_array_i ? any_lock_i : lock_bit_i);
endmodule
`default_nettype wire

// ===== tb/flash_protect_tb.sv
// self-checking bench for the flash protection front end
// assumes the master model paces frames; expectations come from the decode rules
`timescale 1ns/1ps
`default_nettype none
module flash_protect_tb;
	import flash_protect_pkg::*;
	logic mclk_i = 0, rst_i = 1, cpol = 0, wp_n = 1, tbs = 0, sup = 1, last = 0;
	logic [2:0] bp = 3'h0;
	wire logic sel_n, sclk, mosi, miso;
	logic so, soe, ov, orj, wel, got_v, got_r, e;
	logic [2:0] ok, gk;
	logic [ADDR_W-1:0] oa, ga;
	logic [7:0] od, gd;
	logic [63:0] lk, ld;
	logic [5:0] s;
	int failures = 0, total_checks = 0, n;

	always #10 mclk_i = ~mclk_i;
	// undriven output line shows the inverse of its last value
	always @(posedge mclk_i) if (soe === 1'b1) last <= so;
	assign miso = (soe === 1'b1) ? so : ~last;
	// catch one-cycle answer pulses
	always @(posedge mclk_i) begin
		if (ov === 1'b1) begin
			got_v <= 1'b1;
			gk <= ok;
			ga <= oa;
			gd <= od;
		end
		if (orj === 1'b1) got_r <= 1'b1;
	end

	spi_master_model spi_master_model_i (.mclk_i(mclk_i), .cpol_i(cpol), .sel_n_o(sel_n), .sclk_o(sclk),
		.mosi_o(mosi), .miso_i(miso));
	flash_protect #(.PWR_WAIT(10)) flash_protect_i (.mclk_i(mclk_i), .rst_i(rst_i), .sel_n_i(sel_n),
		.sclk_i(sclk), .serial_in_i(mosi), .write_protect_n_i(wp_n), .serial_out_line_o(so),
		.serial_out_line_oe_o(soe), .protect_size_bit0_i(bp[0]), .protect_size_bit1_i(bp[1]),
		.protect_size_bit2_i(bp[2]), .top_bottom_select_i(tbs), .supply_ok_i(sup), .op_valid_o(ov),
		.op_kind_o(ok), .op_addr_o(oa), .op_data_o(od), .op_reject_o(orj), .write_enable_o(wel),
		.lock_bits_o(lk), .lockdown_bits_o(ld));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [63:0] g, input logic [63:0] x, input string m);
		total_checks++;
		if (g !== x) begin
			failures++;
			$display("ERROR %0t %s got %h exp %h", $time, m, g, x);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge mclk_i);
		#1;
	endtask
	task automatic cmd(input logic [39:0] b, input int c);
		got_v = 1'b0;
		got_r = 1'b0;
		spi_master_model_i.xfer(b, c);
	endtask
	// write enable, then the frame; x is {refused, accepted}
	task automatic mod(input logic [39:0] b, input int c, input logic [1:0] x);
		cmd({OP_WREN, 32'h0}, 8);
		cmd(b, c);
		chk({got_r, got_v}, x, "result");
	endtask
	task automatic summarize;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		cyc(3);
		rst_i = 1'b0;
		cyc(20); // power timer shortened to ten cycles
		chk({so, wel, ov, orj, soe, od}, 13'h0ff, "reset outputs");
		chk(lk | ld, 64'h0, "reset locks");
		$display("test reset done");
		mod({OP_PP, 24'h3fff01, 8'h5a}, 40, 2'b01);
		chk(gk, OP_PROG_T, "kind");
		chk(ga, 22'h3fff01, "addr");
		chk(gd, 8'h5a, "data");
		chk(wel, 1'b0, "latch cleared");
		cmd({OP_PP, 24'h0, 8'h00}, 40);
		chk({got_r, got_v}, 2'b10, "no write enable");
		mod({OP_SSE, 24'h0, 8'h00}, 33, 2'b10);
		cmd({OP_PP, 24'h0, 8'h00}, 39);
		chk({got_r, got_v}, 2'b00, "short frame dropped");
		mod({OP_SSE, 24'h012345, 8'h0}, 32, 2'b01);
		chk({gk, ga}, {OP_ERASE_SUB_T, 22'h012000}, "subsector");
		mod({OP_SE, 24'h01ffff, 8'h0}, 32, 2'b01);
		chk({gk, ga}, {OP_ERASE_SEC_T, 22'h010000}, "sector");
		mod({OP_BE, 32'h0}, 8, 2'b01);
		chk({gk, ga}, {OP_ERASE_ALL_T, 22'h0}, "whole");
		mod({OP_POTP, 24'h00003f, 8'ha5}, 40, 2'b01);
		chk({gk, ga}, {OP_OTP_T, 22'h3f}, "otp");
		sup = 1'b0;
		mod({OP_PP, 24'h0, 8'h00}, 40, 2'b10);
		sup = 1'b1;
		cyc(30);
		$display("test commands done");
		cpol = 1'b1;
		tbs = 1'b1;
		bp = 3'h5;
		cmd({OP_WREN, 32'h0}, 8);
		cmd({OP_RDSR, 32'h0}, 16);
		chk(spi_master_model_i.rx[7:0], 8'h56, "status");
		chk(soe, 1'b0, "released");
		mod({OP_PP, 24'h3f0000, 8'h00}, 40, 2'b01);
		cpol = 1'b0;
		$display("test clock mode done");
		for (int t = 0; t < 2; t++) begin
			for (int c = 0; c < 8; c++) begin
				for (int j = 0; j < 2; j++) begin
					tbs = t[0];
					bp = c[2:0];
					wp_n = t[0];
					n = (c == 0) ? 0 : (c == 7) ? 64 : (1 << (c - 1));
					s = 6'(t ? n - 1 + j : 64 - n - j);
					e = t ? (int'(s) < n) : (int'(s) >= 64 - n);
					mod({OP_SE, 2'b0, s, 24'h0}, 32, e ? 2'b10 : 2'b01);
				end
			end
		end
		bp = 3'h0;
		$display("test protect table done");
		cmd({OP_WREN, 32'h0}, 8);
		cmd({OP_WRLR, 24'h050000, 8'h01}, 40);
		chk(lk, 64'h20, "lock set");
		mod({OP_PP, 24'h05ff00, 8'h00}, 40, 2'b10);
		mod({OP_BE, 32'h0}, 8, 2'b10);
		mod({OP_PP, 24'h060000, 8'h00}, 40, 2'b01);
		cmd({OP_WREN, 32'h0}, 8);
		cmd({OP_WRLR, 24'h050000, 8'h03}, 40);
		chk(ld, 64'h20, "lock-down set");
		mod({OP_WRLR, 24'h050000, 8'h00}, 40, 2'b10);
		chk(lk, 64'h20, "lock frozen");
		rst_i = 1'b1;
		cyc(3);
		rst_i = 1'b0;
		cyc(3);
		chk(lk | ld, 64'h0, "reset clears");
		$display("test locks done");
		summarize;
	end

	// watchdog, about three times the expected run
	initial begin
		#1_000_000;
		failures++;
		summarize;
	end
endmodule
`default_nettype wire

// ===== tb/spi_master_model.sv
// bus master model that frames commands onto the flash serial pins
// assumes a 50 MHz core clock; sclk half period is four core cycles
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
	// core clock for pacing, clock mode
	input wire logic mclk_i,
	input wire logic cpol_i,
	// serial pins
	output logic sel_n_o,
	output logic sclk_o,
	output logic mosi_o,
	input wire logic miso_i
);
	logic [15:0] rx;

	// deselected and idle from time zero
	initial begin
		sel_n_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
		rx = 16'h0;
	end

	// ----------------------------------------
	// pacing and framing
	// ----------------------------------------
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	// one frame, msb first; rx keeps the last sixteen bits seen
	task automatic xfer(input logic [39:0] bits, input int n);
		sclk_o = cpol_i;
		wait_cyc(4); // idle level settles before select, no stray edge
		sel_n_o = 1'b0;
		wait_cyc(4);
		for (int i = 0; i < n; i++) begin
			sclk_o = 1'b0;
			mosi_o = bits[39-i];
			wait_cyc(4);
			sclk_o = 1'b1;
			wait_cyc(4);
			rx = {rx[14:0], miso_i}; // late in high phase, data launched at the fall
		end
		sclk_o = cpol_i;
		wait_cyc(4);
		sel_n_o = 1'b1;
		mosi_o = ~mosi_o; // released line shows no stale value
		wait_cyc(8);
	endtask
endmodule
`default_nettype wire
